// ==== bus_match_map.vh ====
// Constants for the port-B bus-matching FIFO pair: queue geometry,
// bus-size encodings, flag levels and skew figures.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef BUS_MATCH_MAP_VH
`define BUS_MATCH_MAP_VH

// Queue geometry
`define QUEUE_WIDTH 36
`define QUEUE_DEPTH 8
`define QUEUE_ADDR_W 3
`define QUEUE_LEVEL_W 4

// Port-B bus size codes {size_select_high, size_select_low}
`define SIZE_LONG 2'h0
`define SIZE_WORD 2'h1
`define SIZE_BYTE 2'h2
`define SIZE_MAIL 2'h3

// Almost-empty flag is low at or below this level, almost-full at or above
`define ALMOST_EMPTY_LEVEL 4'h2
`define ALMOST_FULL_LEVEL 4'h6

// Flag reset value (all flags low while in reset)
`define FLAG_RESET 1'h0

// Skew figures in ns and the ref_clk period they are measured against
`define CLK_PERIOD_NS 20
`define FIRST_SKEW_NS 8
`define SECOND_SKEW_NS 16
// Least times round up to whole cycles, never below one
`define FIRST_SKEW_CYCLES ((`FIRST_SKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECOND_SKEW_CYCLES ((`SECOND_SKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== queue_fifo.v ====
// Single-clock FIFO with valid/ready on both sides and a fill level.
// Assumes both sides share ref_clk; the drain side may stall freely.
`timescale 1ns/100ps
module queue_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter ADDR_W = 3
) (
  input wire ref_clk, // System clock
  input wire srst, // Synchronous reset, active high
  input wire in_valid, // Push request
  output wire in_ready, // Space available
  input wire [WIDTH-1:0] in_data, // Word pushed
  output wire out_valid, // Word available
  input wire out_ready, // Pop request
  output wire [WIDTH-1:0] out_data, // Word at head
  output reg [ADDR_W:0] level // Words stored
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [ADDR_W-1:0] wr_ptr; // Next write slot
  reg [ADDR_W-1:0] rd_ptr; // Head slot
  wire push; // Accepted push
  wire pop; // Accepted pop

  assign in_ready = (level != DEPTH[ADDR_W:0]);
  assign out_valid = (level != {(ADDR_W+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;
  assign out_data = mem[rd_ptr];

  // Storage write; no reset needed on data
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and level
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr <= {ADDR_W{1'b0}};
      rd_ptr <= {ADDR_W{1'b0}};
      level <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

// ==== flag_sync.v ====
// Two-stage flag synchroniser advanced by a port's clock enable.
// Assumes sample_en is a one-cycle pulse marking that port's clock edge.
`timescale 1ns/100ps
`include "bus_match_map.vh"
module flag_sync #(
  parameter WIDTH = 4
) (
  input wire ref_clk, // System clock
  input wire srst, // Synchronous reset, active high
  input wire sample_en, // Port clock edge pulse
  input wire [WIDTH-1:0] raw, // Flags in the source timing
  output wire [WIDTH-1:0] flag // Flags in the port timing
);
  reg [WIDTH-1:0] stage1; // First stage, read only by stage2
  reg [WIDTH-1:0] stage2; // Second stage, drives the output

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Each flag takes two port edges to pass
      always @(posedge ref_clk) begin
        if (srst) begin
          stage1[i] <= `FLAG_RESET;
          stage2[i] <= `FLAG_RESET;
        end else if (sample_en) begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign flag = stage2;
endmodule

// ==== bidir_fifo_flag_sync_bus_match.v ====
// Bidirectional 36-bit FIFO pair with port-B bus matching and byte swap.
// Assumes port clocks arrive as one-cycle enables on ref_clk and that
// all port inputs are synchronous to ref_clk.
`timescale 1ns/100ps
`include "bus_match_map.vh"
module bidir_fifo_flag_sync_bus_match (
  input wire ref_clk, // System clock, 50 MHz
  input wire srst, // Synchronous reset, active high
  input wire port_a_clock, // Port-A clock edge enable pulse
  input wire port_a_chip_select_n, // Port-A select, active low
  input wire port_a_write_read, // High write, low read
  input wire port_a_transfer_enable, // Port-A transfer enable
  input wire port_a_mailbox_select, // High selects mailbox, not queue
  input wire [35:0] port_a_data_in, // Port-A write data
  output reg [35:0] port_a_data_out, // Port-A read data
  input wire port_b_clock, // Port-B clock edge enable pulse
  input wire port_b_chip_select_n, // Port-B select, active low
  input wire port_b_write_read, // High write, low read
  input wire port_b_transfer_enable, // Port-B transfer enable
  input wire port_b_mailbox_select, // High selects mailbox, not queue
  input wire port_b_size_select_low, // Bus size code bit 0
  input wire port_b_size_select_high, // Bus size code bit 1
  input wire swap_code_low, // Swap code bit 0
  input wire swap_code_high, // Swap code bit 1
  input wire port_b_big_endian, // High for big-endian narrow lanes
  input wire [35:0] port_b_data_in, // Port-B write data
  output reg [35:0] port_b_data_out, // Port-B read data
  output wire port_a_empty_flag_n, // Low when B-to-A queue empty
  output wire port_a_almost_empty_flag_n, // Low when B-to-A almost empty
  output wire port_a_full_flag_n, // Low when A-to-B queue full
  output wire port_a_almost_full_flag_n, // Low when A-to-B almost full
  output wire port_b_empty_flag_n, // Low when A-to-B queue empty
  output wire port_b_almost_empty_flag_n, // Low when A-to-B almost empty
  output wire port_b_full_flag_n, // Low when B-to-A queue full
  output wire port_b_almost_full_flag_n // Low when B-to-A almost full
);
  // Long-word lane swap; every code is its own inverse
  function [35:0] swap_word;
    input [35:0] w;
    input [1:0] code;
    begin
      case (code)
        2'h0: swap_word = w;
        2'h1: swap_word = {w[8:0], w[17:9], w[26:18], w[35:27]};
        2'h2: swap_word = {w[17:0], w[35:18]};
        2'h3: swap_word = {w[26:18], w[35:27], w[8:0], w[17:9]};
        default: swap_word = w;
      endcase
    end
  endfunction

  // Byte (or half, for words) position in the swapped word for part idx
  function [1:0] part_pos;
    input [1:0] idx;
    input big;
    input is_byte;
    begin
      if (is_byte) begin
        part_pos = big ? 2'h3 - idx : idx;
      end else begin
        part_pos = big ? {1'b0, ~idx[0]} : {1'b0, idx[0]};
      end
    end
  endfunction

  wire [1:0] b_size; // Current port-B bus size
  wire [1:0] b_swap; // Current swap code
  wire [35:0] a2b_out; // A-to-B queue head
  wire a2b_valid; // A-to-B queue has data
  wire a2b_ready; // A-to-B queue has room
  wire [3:0] a2b_level; // A-to-B fill level
  wire [35:0] b2a_out; // B-to-A queue head
  wire b2a_valid; // B-to-A queue has data
  wire b2a_ready; // B-to-A queue has room
  wire [3:0] b2a_level; // B-to-A fill level
  wire a_write; // Port-A queue write this edge
  wire a_read; // Port-A queue read this edge
  wire b_queue_sel; // Port-B addresses the queue
  wire b_read; // Port-B queue read this edge
  wire b_pop; // Port-B read that takes a new long word
  wire b_write; // Port-B queue write this edge
  wire b_complete; // Port-B write completes a long word
  wire [3:0] a_raw; // Port-A flags before crossing
  wire [3:0] b_raw; // Port-B flags before crossing
  wire [3:0] a_sync; // Port-A flags after crossing
  wire [3:0] b_sync; // Port-B flags after crossing
  reg [35:0] rd_hold; // Swapped long word being read in parts
  reg [1:0] rd_size; // Size latched for the word being read
  reg [1:0] rd_idx; // Next part to read, zero when none pending
  reg [35:0] wr_stage; // Swapped long word being assembled
  reg [1:0] wr_idx; // Next part to write
  reg [35:0] rd_src; // Swapped source word for this read
  reg [35:0] next_stage; // Assembly word after this write
  reg [1:0] rd_last; // Index of last part for the read size
  reg [1:0] wr_last; // Index of last part for the write size
  reg [1:0] pos; // Lane position of the write part

  assign b_size = {port_b_size_select_high, port_b_size_select_low};
  assign b_swap = {swap_code_high, swap_code_low};

  // Queue access decode: select low, mailbox low, enable high
  assign a_write = port_a_clock & ~port_a_chip_select_n & port_a_transfer_enable
                   & port_a_write_read & ~port_a_mailbox_select
                   & port_a_full_flag_n & a2b_ready;
  assign a_read = port_a_clock & ~port_a_chip_select_n & port_a_transfer_enable
                  & ~port_a_write_read & ~port_a_mailbox_select
                  & port_a_empty_flag_n & b2a_valid;
  assign b_queue_sel = port_b_clock & ~port_b_chip_select_n & port_b_transfer_enable
                       & ~port_b_mailbox_select & (b_size != `SIZE_MAIL);
  assign b_read = b_queue_sel & ~port_b_write_read & port_b_empty_flag_n
                  & (a2b_valid | (rd_idx != 2'h0));
  // The long word leaves the queue on its first narrow read
  assign b_pop = b_read & (rd_idx == 2'h0);
  assign b_write = b_queue_sel & port_b_write_read & port_b_full_flag_n & b2a_ready;

  // Part counts: long takes one transfer, word two, byte four
  always @* begin
    case (b_size)
      `SIZE_WORD: wr_last = 2'h1;
      `SIZE_BYTE: wr_last = 2'h3;
      default: wr_last = 2'h0;
    endcase
    case (rd_idx == 2'h0 ? b_size : rd_size)
      `SIZE_WORD: rd_last = 2'h1;
      `SIZE_BYTE: rd_last = 2'h3;
      default: rd_last = 2'h0;
    endcase
  end

  // The long word is pushed only by the write of its last part
  assign b_complete = b_write & (wr_idx == wr_last);

  // Read source: fresh head swapped on first part, held word afterwards
  always @* begin
    rd_src = (rd_idx == 2'h0) ? swap_word(a2b_out, b_swap) : rd_hold;
  end

  // Assembly of a narrow write into the swapped long word
  always @* begin
    next_stage = wr_stage;
    pos = part_pos(wr_idx, port_b_big_endian, b_size == `SIZE_BYTE);
    case (b_size)
      `SIZE_BYTE: next_stage[9*pos +: 9] = port_b_big_endian ? port_b_data_in[35:27]
                                                              : port_b_data_in[8:0];
      `SIZE_WORD: next_stage[18*pos[0] +: 18] = port_b_big_endian ? port_b_data_in[35:18]
                                                                  : port_b_data_in[17:0];
      default: next_stage = port_b_data_in;
    endcase
  end

  // A-to-B queue, filled by port A and drained in parts by port B
  queue_fifo #(
    .WIDTH(`QUEUE_WIDTH),
    .DEPTH(`QUEUE_DEPTH),
    .ADDR_W(`QUEUE_ADDR_W)
  ) u_a_to_b_queue (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(a_write),
    .in_ready(a2b_ready),
    .in_data(port_a_data_in),
    .out_valid(a2b_valid),
    .out_ready(b_pop),
    .out_data(a2b_out),
    .level(a2b_level)
  );

  // B-to-A queue, filled one long word at a time by port B
  queue_fifo #(
    .WIDTH(`QUEUE_WIDTH),
    .DEPTH(`QUEUE_DEPTH),
    .ADDR_W(`QUEUE_ADDR_W)
  ) u_b_to_a_queue (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(b_complete),
    .in_ready(b2a_ready),
    .in_data(swap_word(next_stage, b_swap)),
    .out_valid(b2a_valid),
    .out_ready(a_read),
    .out_data(b2a_out),
    .level(b2a_level)
  );

  // Port-B read sequencing and output lanes
  always @(posedge ref_clk) begin
    if (srst) begin
      rd_hold <= 36'h0;
      rd_size <= `SIZE_LONG;
      rd_idx <= 2'h0;
      port_b_data_out <= 36'h0;
    end else if (b_read) begin
      if (rd_idx == 2'h0) begin
        rd_hold <= rd_src;
        rd_size <= b_size;
      end
      // Advance to the next part or finish the long word
      rd_idx <= (rd_idx == rd_last) ? 2'h0 : rd_idx + 2'h1;
      // Only the active lanes change; the rest keep old data
      case (rd_idx == 2'h0 ? b_size : rd_size)
        `SIZE_BYTE: begin
          if (port_b_big_endian) begin
            port_b_data_out[35:27] <= rd_src[9*part_pos(rd_idx, 1'b1, 1'b1) +: 9];
          end else begin
            port_b_data_out[8:0] <= rd_src[9*part_pos(rd_idx, 1'b0, 1'b1) +: 9];
          end
        end
        `SIZE_WORD: begin
          if (port_b_big_endian) begin
            port_b_data_out[35:18] <= rd_src[18*rd_idx[0] ^ 18 +: 18];
          end else begin
            port_b_data_out[17:0] <= rd_src[18*rd_idx[0] +: 18];
          end
        end
        default: port_b_data_out <= rd_src;
      endcase
    end
  end

  // Port-B write assembly
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_stage <= 36'h0;
      wr_idx <= 2'h0;
    end else if (b_write) begin
      wr_stage <= next_stage;
      wr_idx <= b_complete ? 2'h0 : wr_idx + 2'h1;
    end
  end

  // Port-A read data register
  always @(posedge ref_clk) begin
    if (srst) begin
      port_a_data_out <= 36'h0;
    end else if (a_read) begin
      port_a_data_out <= b2a_out;
    end
  end

  // Raw active-low flags; B empty waits for the last pending part
  assign b_raw[0] = a2b_valid | (rd_idx != 2'h0);
  assign b_raw[1] = (a2b_level > `ALMOST_EMPTY_LEVEL);
  assign b_raw[2] = b2a_ready;
  assign b_raw[3] = (b2a_level < `ALMOST_FULL_LEVEL);
  assign a_raw[0] = b2a_valid;
  assign a_raw[1] = (b2a_level > `ALMOST_EMPTY_LEVEL);
  assign a_raw[2] = a2b_ready;
  assign a_raw[3] = (a2b_level < `ALMOST_FULL_LEVEL);

  // Port-B flags cross on port-B edges
  flag_sync #(
    .WIDTH(4)
  ) u_b_flags (
    .ref_clk(ref_clk),
    .srst(srst),
    .sample_en(port_b_clock),
    .raw(b_raw),
    .flag(b_sync)
  );

  // Port-A flags cross on port-A edges
  flag_sync #(
    .WIDTH(4)
  ) u_a_flags (
    .ref_clk(ref_clk),
    .srst(srst),
    .sample_en(port_a_clock),
    .raw(a_raw),
    .flag(a_sync)
  );

  assign port_b_empty_flag_n = b_sync[0];
  assign port_b_almost_empty_flag_n = b_sync[1];
  assign port_b_full_flag_n = b_sync[2];
  assign port_b_almost_full_flag_n = b_sync[3];
  assign port_a_empty_flag_n = a_sync[0];
  assign port_a_almost_empty_flag_n = a_sync[1];
  assign port_a_full_flag_n = a_sync[2];
  assign port_a_almost_full_flag_n = a_sync[3];
endmodule

// ==== bidir_fifo_flag_sync_bus_match_properties.sv ====
// Checker for the port-B bus-matching FIFO pair: flag timing and lane holds.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module bidir_fifo_flag_sync_bus_match_properties (
  input wire ref_clk, // System clock
  input wire srst, // Sync reset
  input wire port_a_clock, // A edge pulse
  input wire port_b_clock, // B edge pulse
  input wire port_b_chip_select_n, // B select
  input wire port_b_write_read, // B direction
  input wire port_b_transfer_enable, // B enable
  input wire port_b_mailbox_select, // B mailbox
  input wire port_b_size_select_low, // Size bit 0
  input wire port_b_size_select_high, // Size bit 1
  input wire port_b_big_endian, // Lane order
  input wire [35:0] port_b_data_out, // B read data
  input wire port_a_empty_flag_n, // B-to-A empty
  input wire port_a_full_flag_n, // A-to-B full
  input wire port_b_empty_flag_n, // A-to-B empty
  input wire port_b_almost_empty_flag_n // A-to-B almost empty
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [1:0] sz = {port_b_size_select_high, port_b_size_select_low}; // Bus size
  wire rd_b = port_b_clock & ~port_b_chip_select_n & port_b_transfer_enable &
    ~port_b_write_read & ~port_b_mailbox_select; // Queue read request
  reg [1:0] parts; // Narrow parts taken of the current word
  // Count narrow read parts so a falling empty flag can be placed
  always @(posedge ref_clk) begin
    if (srst) begin
      parts <= 2'h0;
    end else if (rd_b && port_b_empty_flag_n && sz != 2'h0) begin
      parts <= (sz == 2'h1) ? {1'b0, ~parts[0]} : parts + 2'h1;
    end
  end
  AST_FLAGS_RESET: assert property ($fell(srst) |-> !(port_a_empty_flag_n |
    port_a_full_flag_n | port_b_empty_flag_n | port_b_almost_empty_flag_n))
    else $error("flag high right after reset");
  AST_B_FLAGS_CLOCKED: assert property (!$past(srst) &&
    !$stable({port_b_empty_flag_n, port_b_almost_empty_flag_n}) |-> $past(port_b_clock))
    else $error("port-B flag moved off a port-B edge");
  AST_A_FLAGS_CLOCKED: assert property (!$past(srst) &&
    !$stable({port_a_empty_flag_n, port_a_full_flag_n}) |-> $past(port_a_clock))
    else $error("port-A flag moved off a port-A edge");
  AST_B_OUT_ON_READ: assert property (!$past(srst) && !$stable(port_b_data_out) |->
    $past(rd_b && port_b_empty_flag_n)) else $error("port-B data moved without a read");
  AST_BYTE_BIG_HOLD: assert property (rd_b && sz == 2'h2 && port_b_big_endian |=>
    $stable(port_b_data_out[26:0])) else $error("unused big byte lanes changed");
  AST_BYTE_LITTLE_HOLD: assert property (rd_b && sz == 2'h2 && !port_b_big_endian |=>
    $stable(port_b_data_out[35:9])) else $error("unused little byte lanes changed");
  AST_WORD_HOLD: assert property (rd_b && sz == 2'h1 |=> ($past(port_b_big_endian) ?
    $stable(port_b_data_out[17:0]) : $stable(port_b_data_out[35:18])))
    else $error("unused word lanes changed");
  AST_EMPTY_AFTER_LAST_PART: assert property ($fell(port_b_empty_flag_n) |->
    parts == 2'h0) else $error("empty flag fell with parts pending");
endmodule
bind bidir_fifo_flag_sync_bus_match bidir_fifo_flag_sync_bus_match_properties i_props (
  .ref_clk(ref_clk), .srst(srst), .port_a_clock(port_a_clock), .port_b_clock(port_b_clock),
  .port_b_chip_select_n(port_b_chip_select_n), .port_b_write_read(port_b_write_read),
  .port_b_transfer_enable(port_b_transfer_enable),
  .port_b_mailbox_select(port_b_mailbox_select),
  .port_b_size_select_low(port_b_size_select_low),
  .port_b_size_select_high(port_b_size_select_high),
  .port_b_big_endian(port_b_big_endian), .port_b_data_out(port_b_data_out),
  .port_a_empty_flag_n(port_a_empty_flag_n), .port_a_full_flag_n(port_a_full_flag_n),
  .port_b_empty_flag_n(port_b_empty_flag_n),
  .port_b_almost_empty_flag_n(port_b_almost_empty_flag_n));

// ==== port_a_model.sv ====
// Port-A bus party: makes the port-A edge pulse and moves whole long words.
// Assumes the flags it watches are those of the design's port A.
`timescale 1ns/100ps
module port_a_model (
  input wire ref_clk, // System clock
  output logic port_a_clock = 1'b0, // A edge pulse
  output logic port_a_chip_select_n = 1'b1, // Select, low active
  output logic port_a_write_read = 1'b0, // Write high
  output logic port_a_transfer_enable = 1'b0, // Transfer enable
  output logic port_a_mailbox_select = 1'b0, // Queue when low
  output logic [35:0] port_a_data_in = 36'h0, // Write data
  input wire [35:0] port_a_data_out, // Read data
  input wire port_a_full_flag_n, // Room in a_to_b_queue
  input wire port_a_empty_flag_n // Data in b_to_a_queue
);
  // One A edge every second system clock
  always @(posedge ref_clk) begin
    port_a_clock <= ~port_a_clock;
  end
  // Hold one request until an A edge takes it; waits up to 200 cycles for the flag to allow it first
  task automatic xfer(input logic wr, input logic [35:0] d, output logic [35:0] q);
    int n;
    n = 0;
    while (!(wr ? port_a_full_flag_n : port_a_empty_flag_n) && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    port_a_chip_select_n <= 1'b0;
    port_a_transfer_enable <= 1'b1;
    port_a_write_read <= wr;
    port_a_mailbox_select <= 1'b0;
    port_a_data_in <= d;
    do @(posedge ref_clk); while (!port_a_clock);
    port_a_chip_select_n <= 1'b1;
    port_a_transfer_enable <= 1'b0;
    port_a_data_in <= ~d;
    #1 q = port_a_data_out;
  endtask
endmodule

// ==== bidir_fifo_flag_sync_bus_match_tb_top.sv ====
// Testbench for the port-B bus-matching FIFO pair.
// Assumes the port-A party model; port B is driven here.
`timescale 1ns/100ps
module bidir_fifo_flag_sync_bus_match_tb_top;
  logic ref_clk, srst = 1'b1, port_b_clock = 1'b0; // Clock, reset, B edge
  logic port_b_chip_select_n = 1'b1, port_b_write_read = 1'b0, port_b_transfer_enable = 1'b0;
  logic port_b_size_select_low = 1'b0, port_b_size_select_high = 1'b0; // Size code
  logic port_b_mailbox_select = 1'b0; // Queue when low
  logic swap_code_low = 1'b0, swap_code_high = 1'b0, port_b_big_endian = 1'b1; // Lanes
  logic [35:0] port_b_data_in = 36'h0, q; // B write data, last read
  wire [35:0] port_b_data_out, port_a_data_in, port_a_data_out; // Data buses
  wire port_a_clock, a_cs_n, a_wr, a_en, a_mbx; // Port-A controls
  wire [7:0] flags; // All eight flags
  logic [1:0] bcnt = 2'h0; // B edge divider
  int fails = 0, tests_run = 0;
  localparam int F_AEMP = 7, F_AAE = 6, F_AFUL = 5, F_BEMP = 3, F_BAE = 2, F_BFUL = 1;
  localparam int F_BAF = 0;
  bidir_fifo_flag_sync_bus_match i_bidir_fifo_flag_sync_bus_match (.ref_clk(ref_clk),
    .srst(srst), .port_a_clock(port_a_clock), .port_a_chip_select_n(a_cs_n),
    .port_a_write_read(a_wr), .port_a_transfer_enable(a_en), .port_a_mailbox_select(a_mbx),
    .port_a_data_in(port_a_data_in), .port_a_data_out(port_a_data_out),
    .port_b_clock(port_b_clock), .port_b_chip_select_n(port_b_chip_select_n),
    .port_b_write_read(port_b_write_read), .port_b_transfer_enable(port_b_transfer_enable),
    .port_b_mailbox_select(port_b_mailbox_select),
    .port_b_size_select_low(port_b_size_select_low),
    .port_b_size_select_high(port_b_size_select_high), .swap_code_low(swap_code_low),
    .swap_code_high(swap_code_high), .port_b_big_endian(port_b_big_endian),
    .port_b_data_in(port_b_data_in), .port_b_data_out(port_b_data_out),
    .port_a_empty_flag_n(flags[7]), .port_a_almost_empty_flag_n(flags[6]),
    .port_a_full_flag_n(flags[5]), .port_a_almost_full_flag_n(flags[4]),
    .port_b_empty_flag_n(flags[3]), .port_b_almost_empty_flag_n(flags[2]),
    .port_b_full_flag_n(flags[1]), .port_b_almost_full_flag_n(flags[0]));
  port_a_model i_port_a_model (.ref_clk(ref_clk), .port_a_clock(port_a_clock),
    .port_a_chip_select_n(a_cs_n), .port_a_write_read(a_wr), .port_a_transfer_enable(a_en),
    .port_a_mailbox_select(a_mbx), .port_a_data_in(port_a_data_in),
    .port_a_data_out(port_a_data_out), .port_a_full_flag_n(flags[5]),
    .port_a_empty_flag_n(flags[7]));
  // 50 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Port-B edge every third system clock, out of step with port A
  always @(posedge ref_clk) begin
    bcnt <= (bcnt == 2'h2) ? 2'h0 : bcnt + 2'h1;
    port_b_clock <= (bcnt == 2'h2);
  end
  function automatic logic [8:0] bsel(input logic [35:0] w, input int i);
    return w[35 - 9 * i -: 9];
  endfunction
  function automatic int mcode(input int c);
    return (c == 1) ? 3 : (c == 3) ? 1 : c;
  endfunction
  function automatic logic [35:0] swapw(input logic [35:0] w, input int m);
    return {bsel(w, m), bsel(w, 1 ^ m), bsel(w, 2 ^ m), bsel(w, 3 ^ m)};
  endfunction
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bounded wait for one flag to reach a level
  task automatic wait_flag(input int k, input logic e, input string nm);
    int n;
    n = 0;
    while (flags[k] !== e && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(nm, {35'h0, e}, {35'h0, flags[k]});
  endtask
  // Flag must still stand after two B edges have passed
  task automatic stay(input int k, input logic e, input string nm);
    repeat (8) @(posedge ref_clk);
    #1 chk(nm, {35'h0, e}, {35'h0, flags[k]});
  endtask
  // One port-B transfer, held until a B edge takes it
  task automatic b_op(input logic wr, input logic [1:0] sz, input logic [1:0] cd,
      input logic big, input logic [35:0] d);
    int n;
    n = 0;
    while (!(wr ? flags[F_BFUL] : flags[F_BEMP]) && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("b_op flag", 36'h1, {35'h0, wr ? flags[F_BFUL] : flags[F_BEMP]});
    @(posedge ref_clk);
    port_b_chip_select_n <= 1'b0;
    port_b_transfer_enable <= 1'b1;
    port_b_write_read <= wr;
    {port_b_size_select_high, port_b_size_select_low} <= sz;
    {swap_code_high, swap_code_low} <= cd;
    port_b_big_endian <= big;
    port_b_data_in <= d;
    do @(posedge ref_clk); while (!port_b_clock);
    port_b_chip_select_n <= 1'b1;
    port_b_transfer_enable <= 1'b0;
    port_b_data_in <= ~d;
    #1 q = port_b_data_out;
  endtask
  // Byte reads under every swap code and both lane orders
  task automatic t_swap();
    logic [35:0] w;
    int m;
    w = {9'h1a1, 9'h0b2, 9'h1c3, 9'h0d4};
    for (int k = 0; k < 8; k++) begin
      m = mcode(k % 4);
      i_port_a_model.xfer(1'b1, w, q);
      wait_flag(F_BEMP, 1'b1, "b empty release");
      for (int p = 0; p < 4; p++) begin
        b_op(1'b0, 2'h2, 2'(k % 4), k < 4, 36'h0);
        chk("byte lane", {27'h0, bsel(w, (k < 4) ? (p ^ m) : ((3 - p) ^ m))},
          {27'h0, (k < 4) ? q[35:27] : q[8:0]});
        if (p < 3) stay(F_BEMP, 1'b1, "b empty mid word");
      end
      wait_flag(F_BEMP, 1'b0, "b empty after last byte");
    end
  endtask
  // Fill a_to_b_queue, free it by narrow and swapped long reads
  task automatic t_a_full();
    for (int i = 0; i < 8; i++) i_port_a_model.xfer(1'b1, {28'h3c5a1e9, 8'(i)}, q);
    wait_flag(F_AFUL, 1'b0, "a full set");
    // A read with the mailbox selected must leave the queue alone
    @(posedge ref_clk) port_b_mailbox_select <= 1'b1;
    b_op(1'b0, 2'h2, 2'h0, 1'b1, 36'h0);
    @(posedge ref_clk) port_b_mailbox_select <= 1'b0;
    stay(F_AFUL, 1'b0, "a full kept by mailbox read");
    b_op(1'b0, 2'h2, 2'h0, 1'b1, 36'h0);
    wait_flag(F_AFUL, 1'b1, "a full after first byte");
    for (int p = 1; p < 4; p++) b_op(1'b0, 2'h2, 2'h0, 1'b1, 36'h0);
    for (int i = 1; i < 5; i++) begin
      b_op(1'b0, 2'h0, 2'(i % 4), 1'b1, 36'h0);
      chk("long swap", swapw({28'h3c5a1e9, 8'(i)}, mcode(i % 4)), q);
      if (i == 2) wait_flag(4, 1'b1, "a almost full released");
    end
    wait_flag(F_BAE, 1'b1, "b almost empty high");
    b_op(1'b0, 2'h1, 2'h0, 1'b1, 36'h0);
    chk("word part 1", {18'h0, 18'h0f168}, {18'h0, q[35:18]});
    wait_flag(F_BAE, 1'b0, "b almost empty first part");
    b_op(1'b0, 2'h1, 2'h0, 1'b1, 36'h0);
    chk("word part 2", {18'h0, 18'h1e905}, {18'h0, q[35:18]});
    for (int i = 6; i < 8; i++) begin
      b_op(1'b0, 2'h0, 2'h0, 1'b1, 36'h0);
      chk("long word", {28'h3c5a1e9, 8'(i)}, q);
    end
    wait_flag(F_BEMP, 1'b0, "b empty drained");
  endtask
  // Fill b_to_a_queue with narrow and long writes, then drain from port A
  task automatic t_b_fill();
    logic [35:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {28'h7e1d2b4, 8'(i)};
      if (i == 0) begin
        for (int p = 0; p < 4; p++) begin
          b_op(1'b1, 2'h2, 2'h0, 1'b1, {bsel(w, p), 27'h0});
          if (p < 3) stay(F_AEMP, 1'b0, "a empty mid word");
        end
        wait_flag(F_AEMP, 1'b1, "a empty after last byte");
      end else if (i == 5 || i == 7) begin
        b_op(1'b1, 2'h1, 2'h0, 1'b1, {w[35:18], 18'h0});
        stay((i == 5) ? F_BAF : F_BFUL, 1'b1, "b flag mid word");
        b_op(1'b1, 2'h1, 2'h0, 1'b1, {w[17:0], 18'h0});
        wait_flag((i == 5) ? F_BAF : F_BFUL, 1'b0, "b flag last part");
      end else begin
        b_op(1'b1, 2'h0, 2'h0, 1'b1, w);
      end
      if (i == 2) wait_flag(F_AAE, 1'b1, "a almost empty");
    end
    for (int i = 0; i < 8; i++) begin
      i_port_a_model.xfer(1'b0, 36'h0, q);
      chk("a read", {28'h7e1d2b4, 8'(i)}, q);
    end
    wait_flag(F_AEMP, 1'b0, "a empty drained");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1 chk("flags in reset", 36'h0, {28'h0, flags});
    repeat (20) @(posedge ref_clk);
    #1 chk("flags idle", 36'h33, {28'h0, flags});
    t_swap();
    t_a_full();
    t_b_fill();
    test_done();
  end
endmodule
